/* logic/cvs_pkg.sv */
// constants and types shared by the command value scaling block
package cvs_pkg;

	// measured values: one lsb = one unit of the selected signal type
	//   voltage 1 mV (signed), current 1 uA, frequency 0.1 Hz, pwm 0.1 %PW
	localparam int unsigned CVS_VW = 16;
	localparam int unsigned CVS_RW = 16;

	typedef enum logic [1:0] {
		CVS_SIG_VOLT = 2'b00,
		CVS_SIG_CURR = 2'b01,
		CVS_SIG_FREQ = 2'b10,
		CVS_SIG_PWM  = 2'b11
	} cvs_sig_e;

	// controller modes that permit deadband setting, and the bipolar operating mode
	localparam logic [2:0] CVS_CM_PQ_OPEN  = 3'h0;
	localparam logic [2:0] CVS_CM_POS_OPEN = 3'h1;
	localparam logic [2:0] CVS_OPMODE_BIP  = 3'h3;

	// register offsets
	localparam logic [3:0] CVS_A_CTRL    = 4'h0;
	localparam logic [3:0] CVS_A_LO_CB   = 4'h1;
	localparam logic [3:0] CVS_A_HI_CB   = 4'h2;
	localparam logic [3:0] CVS_A_LO_IF   = 4'h3;
	localparam logic [3:0] CVS_A_HI_IF   = 4'h4;
	localparam logic [3:0] CVS_A_LO_REF  = 4'h5;
	localparam logic [3:0] CVS_A_HI_REF  = 4'h6;
	localparam logic [3:0] CVS_A_DB      = 4'h7;
	localparam logic [3:0] CVS_A_STATUS  = 4'h8;
	localparam logic [3:0] CVS_A_OUT     = 4'h9;

	// control field positions
	localparam int unsigned CVS_F_CB_EN  = 0;
	localparam int unsigned CVS_F_DB_EN  = 1;
	localparam int unsigned CVS_F_SIG    = 2;
	localparam int unsigned CVS_F_OPMODE = 4;
	localparam int unsigned CVS_F_CMODE  = 8;

	// setting steps in lsb
	localparam logic [15:0] CVS_STEP_VOLT = 16'h00c8; // 0.2 V
	localparam logic [15:0] CVS_STEP_CURR = 16'h012c; // 0.3 mA
	localparam logic [15:0] CVS_STEP_FREQ = 16'h0002; // 0.2 Hz
	localparam logic [15:0] CVS_STEP_PWM  = 16'h0002; // 0.2 %PW
	localparam logic [15:0] CVS_STEP_DB   = 16'h0001; // 0.1 %

	// ranges
	localparam logic [15:0] CVS_MAX_VOLT  = 16'h2710; // 10 V
	localparam logic [15:0] CVS_MIN_VOLTB = 16'hd8f0; // -10 V
	localparam logic [15:0] CVS_MAX_CURR  = 16'h4e20; // 20 mA
	localparam logic [15:0] CVS_MIN_FREQ  = 16'h0032; // 5 Hz
	localparam logic [15:0] CVS_MAX_FREQ  = 16'hc350; // 5000 Hz
	localparam logic [15:0] CVS_MAX_PWM   = 16'h03e8; // 100 %PW
	localparam logic [15:0] CVS_MAX_DB    = 16'h01f4; // 50 %

	// defaults per signal type, then reset values
	localparam logic [15:0] CVS_DLCB_VOLT = 16'h01f4; // 0.5 V
	localparam logic [15:0] CVS_DLCB_CURR = 16'h0dac; // 3.5 mA
	localparam logic [15:0] CVS_DLCB_FREQ = 16'h0064; // 10 Hz
	localparam logic [15:0] CVS_DLCB_PWM  = 16'h0064; // 10 %PW
	localparam logic [15:0] CVS_DLIF_VOLT = 16'h0000;
	localparam logic [15:0] CVS_DLIF_CURR = 16'h0000;
	localparam logic [15:0] CVS_DLIF_FREQ = 16'h0032; // 5 Hz
	localparam logic [15:0] CVS_DLIF_PWM  = 16'h0032; // 5 %PW
	localparam logic [15:0] CVS_DHIF_PWM  = 16'h03b6; // 95 %PW
	localparam logic [15:0] CVS_RST_LOREF = 16'h0000; // 0.00 mm
	localparam logic [15:0] CVS_RST_HIREF = 16'h2710; // 100.00 mm
	localparam logic [15:0] CVS_RST_DB    = 16'h0000;
	localparam logic [15:0] CVS_RST_CTRL  = 16'h0000;

endpackage : cvs_pkg

/* logic/cvs_limit.sv */
// range and step check for one setting of a given signal type
`timescale 1ns/1ps
module cvs_limit (
	// setting under test
	input  wire logic [15:0] i_val,
	input  wire logic [1:0]  i_sig,
	input  wire logic        i_bipolar,
	// verdict
	output logic             o_ok
);
	import cvs_pkg::*;

	logic signed [15:0] sval;
	logic        [15:0] lo;
	logic        [15:0] hi;
	logic        [15:0] step;
	logic        [15:0] off;
	logic               in_rng;

	always_comb begin
		sval   = signed'(i_val);
		lo     = 16'h0000;
		hi     = CVS_MAX_VOLT;
		step   = CVS_STEP_VOLT;
		in_rng = 1'b0;
		case (cvs_sig_e'(i_sig))
			CVS_SIG_VOLT: begin
				lo   = i_bipolar ? CVS_MIN_VOLTB : 16'h0000;
				in_rng = (sval >= signed'(lo))
					&& (sval <= signed'(CVS_MAX_VOLT));
			end
			CVS_SIG_CURR: begin
				hi   = CVS_MAX_CURR;
				step = CVS_STEP_CURR;
				in_rng = i_val <= hi;
			end
			CVS_SIG_FREQ: begin
				lo   = CVS_MIN_FREQ;
				hi   = CVS_MAX_FREQ;
				step = CVS_STEP_FREQ;
				in_rng = (i_val >= lo) && (i_val <= hi);
			end
			CVS_SIG_PWM: begin
				hi   = CVS_MAX_PWM;
				step = CVS_STEP_PWM;
				in_rng = i_val <= hi;
			end
			default: in_rng = 1'b0;
		endcase
		// step counted from the bottom of the range
		off  = i_val - lo;
		o_ok = in_rng && ((off % step) == 16'h0000);
	end

endmodule : cvs_limit

/* logic/cvs_map.sv */
// linear map of input between two interface points onto two references
`timescale 1ns/1ps
module cvs_map #(
	parameter int unsigned VW = 16
) (
	// input and scaling points
	input  wire logic signed [VW-1:0] i_x,
	input  wire logic signed [VW-1:0] i_x_lo,
	input  wire logic signed [VW-1:0] i_x_hi,
	input  wire logic signed [VW-1:0] i_y_lo,
	input  wire logic signed [VW-1:0] i_y_hi,
	// mapped value
	output logic signed [VW-1:0]      o_y
);
	logic signed [VW+1:0]   dx;
	logic signed [VW+1:0]   span_x;
	logic signed [VW+1:0]   span_y;
	logic signed [2*VW+3:0] prod;
	logic signed [2*VW+3:0] quot;
	logic signed [2*VW+3:0] sum;

	// outside the interface window the line is extended; divider kept
	// combinational since settings change rarely and area beats latency
	always_comb begin
		dx     = (VW+2)'(i_x) - (VW+2)'(i_x_lo);
		span_x = (VW+2)'(i_x_hi) - (VW+2)'(i_x_lo);
		span_y = (VW+2)'(i_y_hi) - (VW+2)'(i_y_lo);
		prod   = (2*VW+4)'(dx) * (2*VW+4)'(span_y);
		if (span_x == '0) begin
			quot = '0;
		end else begin
			quot = prod / (2*VW+4)'(span_x);
		end
		sum = quot + (2*VW+4)'(i_y_lo);
		o_y = sum[VW-1:0];
	end

endmodule : cvs_map

/* logic/cvs_top.sv */
// command value scaling: cable break, interface scaling, deadband
`timescale 1ns/1ps
// Behaviour
// - cable-break supervision enable bit; off means no cable-break flag
// - supervision on: input below lower threshold raises cable break
// - supervision on: input above upper threshold raises cable break
// - signal type change reloads thresholds and interface points to defaults
// - settings limited to the type's range and step, else write ignored
// - voltage interface points may go to -10 V only in mode 3
// - input at lower interface point gives lower reference
// - input at upper interface point gives upper reference
// - deadband acts on the merged command value input
// - deadband settings writable only in the two open loop modes
// - deadband off passes merged command unchanged
// - deadband on: below it zero current, else min-to-max current (the code passes the merged command on unchanged at and above it)
// - default thresholds and interface points per signal type
module cvs_top #(
	parameter int unsigned VW = cvs_pkg::CVS_VW
) (
	// clock and reset
	input  wire logic              i_sys_clk,
	input  wire logic              i_nrst,
	// register port
	input  wire logic [3:0]        i_addr,
	input  wire logic [15:0]       i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [15:0]       o_rdata,
	// measured command input and merged command
	input  wire logic [VW-1:0]     i_meas,
	input  wire logic [VW-1:0]     i_merged,
	// results
	output logic      [VW-1:0]     o_scaled,
	output logic      [VW-1:0]     o_cmd,
	output logic                   o_sol_zero,
	output logic                   o_cable_break
);
	import cvs_pkg::*;

	// settings
	logic        cb_en, next_cb_en;
	logic        db_en, next_db_en;
	logic [1:0]  sig, next_sig;
	logic [2:0]  opmode, next_opmode;
	logic [2:0]  cmode, next_cmode;
	logic [15:0] lo_cb, next_lo_cb;
	logic [15:0] hi_cb, next_hi_cb;
	logic [15:0] lo_if, next_lo_if;
	logic [15:0] hi_if, next_hi_if;
	logic [15:0] lo_ref, next_lo_ref;
	logic [15:0] hi_ref, next_hi_ref;
	logic [15:0] db, next_db;
	// outputs
	logic [15:0] next_rdata;
	logic [VW-1:0] next_scaled;
	logic [VW-1:0] next_cmd;
	logic        next_sol_zero;
	logic        next_cb;

	logic        ok_w;
	logic        bip;
	logic        db_open;
	logic        below;
	logic        above;
	logic [VW-1:0] map_y;
	logic [15:0] d_lo_cb;
	logic [15:0] d_hi_cb;
	logic [15:0] d_lo_if;
	logic [15:0] d_hi_if;

	assign bip     = (opmode == CVS_OPMODE_BIP);
	assign db_open = (cmode == CVS_CM_PQ_OPEN)
		|| (cmode == CVS_CM_POS_OPEN);

	// one checker for the addressed setting on the current type
	cvs_limit u_limit (
		.i_val     (i_wdata),
		.i_sig     (sig),
		.i_bipolar (bip && (i_addr == CVS_A_LO_IF || i_addr == CVS_A_HI_IF)),
		.o_ok      (ok_w)
	);

	cvs_map #(
		.VW (VW)
	) u_map (
		.i_x    (signed'(i_meas)),
		.i_x_lo (signed'(lo_if)),
		.i_x_hi (signed'(hi_if)),
		.i_y_lo (signed'(lo_ref)),
		.i_y_hi (signed'(hi_ref)),
		.o_y    (map_y)
	);

	// defaults of the type being selected
	always_comb begin
		d_lo_cb = CVS_DLCB_VOLT;
		d_hi_cb = CVS_MAX_VOLT;
		d_lo_if = CVS_DLIF_VOLT;
		d_hi_if = CVS_MAX_VOLT;
		case (cvs_sig_e'(i_wdata[CVS_F_SIG +: 2]))
			CVS_SIG_VOLT: begin
				d_lo_cb = CVS_DLCB_VOLT;
			end
			CVS_SIG_CURR: begin
				d_lo_cb = CVS_DLCB_CURR;
				d_hi_cb = CVS_MAX_CURR;
				d_lo_if = CVS_DLIF_CURR;
				d_hi_if = CVS_MAX_CURR;
			end
			CVS_SIG_FREQ: begin
				d_lo_cb = CVS_DLCB_FREQ;
				d_hi_cb = CVS_MAX_FREQ;
				d_lo_if = CVS_DLIF_FREQ;
				d_hi_if = CVS_MAX_FREQ;
			end
			CVS_SIG_PWM: begin
				d_lo_cb = CVS_DLCB_PWM;
				d_hi_cb = CVS_MAX_PWM;
				d_lo_if = CVS_DLIF_PWM;
				d_hi_if = CVS_DHIF_PWM;
			end
			default: d_lo_cb = CVS_DLCB_VOLT;
		endcase
	end

	// register writes
	always_comb begin
		next_cb_en  = cb_en;
		next_db_en  = db_en;
		next_sig    = sig;
		next_opmode = opmode;
		next_cmode  = cmode;
		next_lo_cb  = lo_cb;
		next_hi_cb  = hi_cb;
		next_lo_if  = lo_if;
		next_hi_if  = hi_if;
		next_lo_ref = lo_ref;
		next_hi_ref = hi_ref;
		next_db     = db;
		if (i_wr) begin
			case (i_addr)
				CVS_A_CTRL: begin
					next_cb_en  = i_wdata[CVS_F_CB_EN];
					next_sig    = i_wdata[CVS_F_SIG +: 2];
					next_opmode = i_wdata[CVS_F_OPMODE +: 3];
					next_cmode  = i_wdata[CVS_F_CMODE +: 3];
					// enable bit only moves in an open loop mode
					if (db_open) begin
						next_db_en = i_wdata[CVS_F_DB_EN];
					end
					if (i_wdata[CVS_F_SIG +: 2] != sig) begin
						next_lo_cb = d_lo_cb;
						next_hi_cb = d_hi_cb;
						next_lo_if = d_lo_if;
						next_hi_if = d_hi_if;
					end
				end
				// off-grid or out-of-range values are dropped
				CVS_A_LO_CB: if (ok_w) next_lo_cb = i_wdata;
				CVS_A_HI_CB: if (ok_w) next_hi_cb = i_wdata;
				CVS_A_LO_IF: if (ok_w) next_lo_if = i_wdata;
				CVS_A_HI_IF: if (ok_w) next_hi_if = i_wdata;
				CVS_A_LO_REF: next_lo_ref = i_wdata;
				CVS_A_HI_REF: next_hi_ref = i_wdata;
				CVS_A_DB: begin
					if (db_open && i_wdata <= CVS_MAX_DB) begin
						next_db = i_wdata;
					end
				end
				default: next_db = db;
			endcase
		end
	end

	// supervision, deadband and read path
	always_comb begin
		if (sig == CVS_SIG_VOLT) begin
			below = signed'(i_meas) < signed'(lo_cb);
			above = signed'(i_meas) > signed'(hi_cb);
		end else begin
			below = i_meas < lo_cb;
			above = i_meas > hi_cb;
		end
		next_cb = cb_en && (below || above);
		next_scaled = map_y;
		// merged value in 0.1 % of the current range, signed compare so any negative value gives zero
		if (db_en && (signed'(i_merged) < signed'(db))) begin
			next_cmd      = '0;
			next_sol_zero = 1'b1;
		end else begin
			next_cmd      = i_merged;
			next_sol_zero = 1'b0;
		end
		next_rdata = 16'h0000;
		if (i_rd) begin
			case (i_addr)
				CVS_A_CTRL: next_rdata = {5'h00, cmode, 1'b0, opmode,
					sig, db_en, cb_en};
				CVS_A_LO_CB:  next_rdata = lo_cb;
				CVS_A_HI_CB:  next_rdata = hi_cb;
				CVS_A_LO_IF:  next_rdata = lo_if;
				CVS_A_HI_IF:  next_rdata = hi_if;
				CVS_A_LO_REF: next_rdata = lo_ref;
				CVS_A_HI_REF: next_rdata = hi_ref;
				CVS_A_DB:     next_rdata = db;
				CVS_A_STATUS: next_rdata = {15'h0000, o_cable_break};
				CVS_A_OUT:    next_rdata = 16'(o_scaled);
				default:      next_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cb_en         <= 1'b0;
			db_en         <= 1'b0;
			sig           <= CVS_SIG_VOLT;
			opmode        <= 3'h1;
			cmode         <= CVS_CM_PQ_OPEN;
			lo_cb         <= CVS_DLCB_VOLT;
			hi_cb         <= CVS_MAX_VOLT;
			lo_if         <= CVS_DLIF_VOLT;
			hi_if         <= CVS_MAX_VOLT;
			lo_ref        <= CVS_RST_LOREF;
			hi_ref        <= CVS_RST_HIREF;
			db            <= CVS_RST_DB;
			o_rdata       <= 16'h0000;
			o_scaled      <= '0;
			o_cmd         <= '0;
			o_sol_zero    <= 1'b0;
			o_cable_break <= 1'b0;
		end else begin
			cb_en         <= next_cb_en;
			db_en         <= next_db_en;
			sig           <= next_sig;
			opmode        <= next_opmode;
			cmode         <= next_cmode;
			lo_cb         <= next_lo_cb;
			hi_cb         <= next_hi_cb;
			lo_if         <= next_lo_if;
			hi_if         <= next_hi_if;
			lo_ref        <= next_lo_ref;
			hi_ref        <= next_hi_ref;
			db            <= next_db;
			o_rdata       <= next_rdata;
			o_scaled      <= next_scaled;
			o_cmd         <= next_cmd;
			o_sol_zero    <= next_sol_zero;
			o_cable_break <= next_cb;
		end
	end

endmodule : cvs_top

/* tb/cvs_src_model.sv */
// command signal source standing in front of the measured input
`timescale 1ns/1ps
module cvs_src_model (
	// clock
	input  wire logic        i_sys_clk,
	// level asked for by the bench
	input  wire logic [15:0] i_level,
	// measured value seen by the block
	output logic      [15:0] o_meas
);
	// one sample of acquisition delay, like a real converter
	always_ff @(posedge i_sys_clk) begin
		o_meas <= i_level;
	end
endmodule : cvs_src_model

/* tb/cvs_top_properties.sv */
// concurrent checks on the ports of the command value scaling block
`timescale 1ns/1ps
module cvs_top_properties
	import cvs_pkg::*;
#(
	parameter int unsigned VW = 16
) (
	// clock and reset
	input wire logic          i_sys_clk,
	input wire logic          i_nrst,
	// register port
	input wire logic [3:0]    i_addr,
	input wire logic          i_wr,
	input wire logic          i_rd,
	input wire logic [15:0]   o_rdata,
	// datapath
	input wire logic [VW-1:0] i_meas,
	input wire logic [VW-1:0] i_merged,
	input wire logic [VW-1:0] o_scaled,
	input wire logic [VW-1:0] o_cmd,
	input wire logic          o_sol_zero,
	input wire logic          o_cable_break
);
	default clocking cb_clk @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_nrst);

	a_rdata_idle_zero: assert property (
		!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("read data not zero outside a read");
	a_status_read: assert property (
		$past(i_rd) && $past(i_addr) == CVS_A_STATUS
		|-> o_rdata == {15'h0000, $past(o_cable_break)})
		else $error("status read differs from cable break");
	a_scaled_read: assert property (
		$past(i_rd) && $past(i_addr) == CVS_A_OUT
		|-> o_rdata == $past(o_scaled))
		else $error("output read differs from scaled value");
	a_unmapped_read: assert property (
		$past(i_rd) && $past(i_addr) > CVS_A_OUT |-> o_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_zero_cmd: assert property (
		o_sol_zero |-> o_cmd == '0)
		else $error("zero current flag with nonzero command");
	a_zero_below_max: assert property (
		o_sol_zero |-> $signed($past(i_merged)) < $signed(CVS_MAX_DB))
		else $error("zero current above widest deadband");
	a_cmd_passes: assert property (
		!o_sol_zero |-> o_cmd == $past(i_merged))
		else $error("merged command altered outside deadband");
	a_steady_out: assert property (
		(!i_wr && $stable(i_meas) && $stable(i_merged)) [*2]
		|=> $stable(o_scaled) && $stable(o_cable_break) && $stable(o_cmd))
		else $error("outputs moved with steady inputs");
endmodule : cvs_top_properties

/* tb/cvs_top_tb.sv */
// self-checking bench for the command value scaling block
`timescale 1ns/1ps
module cvs_top_tb;
	import cvs_pkg::*;
	logic        i_sys_clk = 1'b0;
	logic        i_nrst    = 1'b0;
	logic [3:0]  i_addr    = 4'h0;
	logic [15:0] i_wdata   = 16'h0000;
	logic        i_wr      = 1'b0;
	logic        i_rd      = 1'b0;
	logic [15:0] lvl       = 16'h0000;
	logic [15:0] i_merged  = 16'h0000;
	logic [15:0] i_meas, o_rdata, o_scaled, o_cmd, ctrl, x, y;
	logic        o_sol_zero, o_cable_break;
	logic        rd_d      = 1'b0;
	logic [15:0] lfsr      = 16'h82fd;
	logic [15:0] exp_q[$];
	int          fails     = 0;
	int          cmp_count = 0;
	int          seq[5]    = '{0, 3, 2, 1, 0};
	logic [15:0] dflt[4][4] = '{
		'{CVS_DLCB_VOLT, CVS_MAX_VOLT, CVS_DLIF_VOLT, CVS_MAX_VOLT},
		'{CVS_DLCB_CURR, CVS_MAX_CURR, CVS_DLIF_CURR, CVS_MAX_CURR},
		'{CVS_DLCB_FREQ, CVS_MAX_FREQ, CVS_DLIF_FREQ, CVS_MAX_FREQ},
		'{CVS_DLCB_PWM, CVS_MAX_PWM, CVS_DLIF_PWM, CVS_DHIF_PWM}};

	cvs_src_model u_src (.i_sys_clk(i_sys_clk), .i_level(lvl), .o_meas(i_meas));
	cvs_top dut_u (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_meas(i_meas), .i_merged(i_merged), .o_scaled(o_scaled),
		.o_cmd(o_cmd), .o_sol_zero(o_sol_zero), .o_cable_break(o_cable_break));

	initial begin
		forever #5 i_sys_clk = ~i_sys_clk;
	end

	function automatic logic [15:0] nxt(logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : nxt

	task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd(logic [3:0] a, logic [15:0] e);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		exp_q.push_back(e);
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
	endtask : rd

	// source delay plus block latency, then settle
	task automatic dp(logic [15:0] m, logic [15:0] g);
		@(posedge i_sys_clk);
		lvl <= m;
		i_merged <= g;
		repeat (2) @(posedge i_sys_clk);
		#1;
	endtask : dp

	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results

	// read data stands only in the cycle after the strobe
	always @(posedge i_sys_clk) begin
		rd_d <= i_rd;
		if (rd_d) check("rdata", o_rdata, exp_q.pop_front());
	end

	initial begin
		repeat (20000) @(posedge i_sys_clk);
		fails++;
		results();
	end

	initial begin
		repeat (4) @(posedge i_sys_clk);
		i_nrst <= 1'b1;
		rd(4'hf, 16'h0000);
		foreach (seq[i]) begin
			wr(CVS_A_CTRL, (16'(seq[i]) << CVS_F_SIG) | 16'h0010);
			for (int r = 0; r < 4; r++) rd(4'(r + 1), dflt[seq[i]][r]);
			if (i == 0) begin
				wr(CVS_A_LO_CB, 16'h0258);
				wr(CVS_A_HI_CB, 16'h2710);
				wr(CVS_A_LO_CB, 16'h0259);
				rd(CVS_A_LO_CB, 16'h0258);
			end
		end
		wr(CVS_A_LO_IF, CVS_MIN_VOLTB);
		rd(CVS_A_LO_IF, 16'h0000);
		ctrl = 16'h0030;
		wr(CVS_A_CTRL, ctrl);
		wr(CVS_A_LO_IF, CVS_MIN_VOLTB);
		rd(CVS_A_LO_IF, CVS_MIN_VOLTB);
		wr(CVS_A_LO_IF, 16'h0000);
		dp(16'h0190, 16'h0000);
		check("cb off", {15'h0, o_cable_break}, 16'h0000);
		ctrl = ctrl | 16'h0001;
		wr(CVS_A_CTRL, ctrl);
		dp(16'h0190, 16'h0000);
		check("cb low", {15'h0, o_cable_break}, 16'h0001);
		rd(CVS_A_STATUS, 16'h0001);
		dp(16'h01f4, 16'h0000);
		check("cb edge", {15'h0, o_cable_break}, 16'h0000);
		dp(16'h2711, 16'h0000);
		check("cb high", {15'h0, o_cable_break}, 16'h0001);
		dp(16'h2710, 16'h0000);
		check("cb top", {15'h0, o_cable_break}, 16'h0000);
		wr(CVS_A_LO_REF, 16'h03e8);
		wr(CVS_A_HI_REF, 16'h0bb8);
		for (int k = 0; k < 8; k++) begin
			lfsr = nxt(lfsr);
			x = (k == 0) ? 16'h0000 : (k == 1) ? 16'h2710 : lfsr % 16'h2711;
			y = 16'h03e8 + x / 16'h0005;
			dp(x, 16'h0000);
			check("scaled", o_scaled, y);
		end
		rd(CVS_A_OUT, y);
		dp(16'h0000, 16'h0000);
		check("at lower", o_scaled, 16'h03e8);
		dp(16'h2710, 16'h0000);
		check("at upper", o_scaled, 16'h0bb8);
		// enable bit is judged on the mode already in force
		wr(CVS_A_CTRL, ctrl | 16'h0200);
		wr(CVS_A_CTRL, ctrl | 16'h0202);
		rd(CVS_A_CTRL, ctrl | 16'h0200);
		wr(CVS_A_DB, 16'h0064);
		rd(CVS_A_DB, 16'h0000);
		dp(16'h1388, 16'hfffb);
		check("no db", o_cmd, 16'hfffb);
		wr(CVS_A_CTRL, ctrl | 16'h0100);
		wr(CVS_A_CTRL, ctrl | 16'h0102);
		wr(CVS_A_DB, 16'h0064);
		wr(CVS_A_DB, 16'h01f5);
		rd(CVS_A_DB, 16'h0064);
		dp(16'h1388, 16'h0063);
		check("below db", o_cmd, 16'h0000);
		check("zero", {15'h0, o_sol_zero}, 16'h0001);
		dp(16'h1388, 16'h0064);
		check("at db", o_cmd, 16'h0064);
		wr(CVS_A_CTRL, ctrl);
		dp(16'h1388, 16'h0063);
		check("db off", o_cmd, 16'h0063);
		for (int k = 0; k < 10 && exp_q.size() > 0; k++) @(posedge i_sys_clk);
		if (exp_q.size() > 0) fails++;
		results();
	end
endmodule : cvs_top_tb

bind cvs_top cvs_top_properties #(.VW(VW)) u_props (
	.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wr(i_wr),
	.i_rd(i_rd), .o_rdata(o_rdata), .i_meas(i_meas), .i_merged(i_merged),
	.o_scaled(o_scaled), .o_cmd(o_cmd), .o_sol_zero(o_sol_zero),
	.o_cable_break(o_cable_break));
